// [dac_host_pkg.sv]
/*
  Constants for the parallel converter host controller: pin timing counts,
  code constants and power-down encodings.
  Assumes a 20 MHz system clock; the converter itself has no clock.
*/
// Overview of operation
// - 16-bit two-way data bus, bit 15 first line.
// - select active low; high means bus ignored.
// - write: read_not_write low around select low.
// - write data held through select rising edge.
// - tied-low select still needs load strobe pulse.
package dac_host_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned DATA_W = 16;
  // pin timing minima in ns
  localparam int unsigned T_CS_WR_LOW_NS = 20;
  localparam int unsigned T_CS_RD_LOW_NS = 80;   // read data valid delay max
  localparam int unsigned T_RW_SETUP_NS = 30;
  localparam int unsigned T_HOLD_NS = 15;
  localparam int unsigned T_CS_HIGH_NS = 80;
  localparam int unsigned T_LD_PULSE_NS = 40;
  localparam int unsigned T_LD_TO_CS_NS = 50;
  localparam int unsigned T_RST_PULSE_NS = 40;
  localparam int unsigned T_RESET_LEVEL_HOLD_NS = 20;
  localparam int unsigned NS_PER_CLK = 1_000_000_000 / CLK_HZ;
  function automatic int unsigned cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + NS_PER_CLK - 1) / NS_PER_CLK;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned C_WR_LOW = cyc(T_CS_WR_LOW_NS);
  // two more cycles so the sampled bus passes the two-stage synchroniser
  localparam int unsigned C_RD_LOW = cyc(T_CS_RD_LOW_NS) + 2;
  localparam int unsigned C_SETUP = cyc(T_RW_SETUP_NS);
  localparam int unsigned C_HOLD = cyc(T_HOLD_NS);
  localparam int unsigned C_CS_HIGH = cyc(T_CS_HIGH_NS);
  localparam int unsigned C_LD_PULSE = cyc(T_LD_PULSE_NS);
  localparam int unsigned C_LD_TO_CS = cyc(T_LD_TO_CS_NS);
  localparam int unsigned C_RST_PULSE = cyc(T_RST_PULSE_NS);
  localparam int unsigned C_RST_HOLD = cyc(T_RESET_LEVEL_HOLD_NS);
  localparam int unsigned CNT_W = 4;
  // codes
  localparam logic [15:0] CODE_MIN_TWOS = 16'h8000;
  localparam logic [15:0] CODE_MID_TWOS = 16'h0000;
  localparam logic [15:0] CODE_MIN_BIN = 16'h0000;
  localparam logic [15:0] CODE_FULL_BIN = 16'hFFFF;
  // power-down encodings {sel1, sel0}
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_HIZ = 2'h3;
  // command codes
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_LOAD = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;
endpackage

// [dac_host_sync.sv]
/*
  Two-flip-flop synchroniser for the readback data bus.
  Assumes the bus is stable while sampled late in a read strobe.
*/
module dac_host_sync #(
  parameter int unsigned W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// [dac_host_ctrl.sv]
/*
  Host-side controller for a clockless 16-bit parallel converter.
  Takes one command at a time (write, read back, load, reset) and
  sequences the select, read_not_write, load and reset pins.
  Format and power-down selects are passed from user levels.
  Assumes a single synchronous clock at 20 MHz and that the device
  is alone on its data bus.
*/
module dac_host_ctrl (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // user command port
  input wire logic CMD_VALID_I,
  input wire logic [1:0] CMD_I,
  input wire logic [15:0] CMD_DATA_I,
  input wire logic CMD_RESET_LEVEL_I,
  input wire logic FORMAT_I,
  input wire logic [1:0] PD_I,
  output logic CMD_READY_O,
  output logic DONE_O,
  output logic [15:0] RD_DATA_O,
  // device pins
  output logic DEV_SELECT_N_O,
  output logic READ_NOT_WRITE_O,
  input wire logic [15:0] DATA_BUS_LINES_I,
  output logic [15:0] DATA_BUS_LINES_O,
  output logic DATA_BUS_LINES_OE_O,
  output logic LOAD_OUTPUT_STROBE_O,
  output logic OUTPUT_RESET_STROBE_O,
  output logic RESET_LEVEL_SELECT_O,
  output logic CODE_FORMAT_SELECT_O,
  output logic POWERDOWN_SEL1_O,
  output logic POWERDOWN_SEL0_O
);
  localparam int unsigned CW = dac_host_pkg::CNT_W;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_ACTIVE, ST_HOLD, ST_GAP, ST_STROBE, ST_AFTER
  } state_e;

  state_e state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [1:0] cmd_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic sel_n_r, rnw_r, oe_r, ld_r, rs_r, rssel_r, done_r;
  logic fmt_r;
  logic [1:0] pd_r;
  logic [15:0] bus_sync;

  // readback path passes two flops before use
  dac_host_sync #(.W(dac_host_pkg::DATA_W)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .d_i(DATA_BUS_LINES_I),
    .q_o(bus_sync)
  );

  function automatic logic [CW-1:0] cnt_of(input int unsigned c);
    return CW'(c - 1);
  endfunction

  function automatic logic cmd_is(input logic [1:0] c,
                                  input logic [1:0] k);
    return c == k;
  endfunction

  wire take = (state_r == ST_IDLE) && CMD_VALID_I;
  // cmd_r only updates at take, so the first pin levels of a new
  // command come from the port, or they would follow the old one
  wire [1:0] cmd_cur = take ? CMD_I : cmd_r;
  wire is_write = cmd_is(cmd_cur, dac_host_pkg::CMD_WRITE);
  wire is_read = cmd_is(cmd_cur, dac_host_pkg::CMD_READ);
  wire is_load = cmd_is(cmd_cur, dac_host_pkg::CMD_LOAD);
  wire is_reset = cmd_is(cmd_cur, dac_host_pkg::CMD_RESET);
  wire is_bus_cmd = is_write || is_read;
  wire cnt_zero = (cnt_r == '0);
  wire [CW-1:0] active_len = is_read ? cnt_of(dac_host_pkg::C_RD_LOW)
                                     : cnt_of(dac_host_pkg::C_WR_LOW);
  wire [CW-1:0] strobe_len = is_load ? cnt_of(dac_host_pkg::C_LD_PULSE)
                                     : cnt_of(dac_host_pkg::C_RST_PULSE);
  wire [CW-1:0] after_len = is_load ? cnt_of(dac_host_pkg::C_LD_TO_CS)
                                    : cnt_of(dac_host_pkg::C_RST_HOLD);

  // each phase counts down to zero; n cycles load a count of n-1
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_zero ? cnt_r : CW'(cnt_r - 1'b1);
    case (state_r)
      ST_IDLE: begin
        if (CMD_VALID_I) begin
          state_nxt = ST_SETUP;
          cnt_nxt = cnt_of(dac_host_pkg::C_SETUP);
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          state_nxt = is_bus_cmd ? ST_ACTIVE : ST_STROBE;
          cnt_nxt = is_bus_cmd ? active_len : strobe_len;
        end
      end
      ST_ACTIVE: begin
        if (cnt_zero) begin
          state_nxt = ST_HOLD;
          cnt_nxt = cnt_of(dac_host_pkg::C_HOLD);
        end
      end
      ST_HOLD: begin
        if (cnt_zero) begin
          state_nxt = ST_GAP;
          cnt_nxt = cnt_of(dac_host_pkg::C_CS_HIGH);
        end
      end
      ST_STROBE: begin
        if (cnt_zero) begin
          state_nxt = ST_AFTER;
          cnt_nxt = after_len;
        end
      end
      ST_AFTER: begin
        if (cnt_zero) begin
          state_nxt = ST_GAP;
          // strobe length doubles as the gap: nothing waits on it
          cnt_nxt = strobe_len;
        end
      end
      ST_GAP: begin
        if (cnt_zero) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // pin levels decoded from next state so pins come from flops
  wire sel_n_nxt = !(is_bus_cmd && (state_nxt == ST_ACTIVE));
  // write keeps rnw low from setup through the gap; read keeps it high
  wire rnw_nxt = (state_nxt == ST_IDLE) || !is_write;
  wire oe_nxt = !is_read && is_bus_cmd &&
                (state_nxt == ST_SETUP || state_nxt == ST_ACTIVE ||
                 state_nxt == ST_HOLD);
  wire ld_nxt = is_load &&
                (state_nxt == ST_AFTER);
  wire rs_nxt = is_reset &&
                (state_nxt == ST_AFTER);
  // the synchroniser lags the pins by two edges, so the read low
  // phase is stretched by two cycles and captures on its last one
  wire capture = is_read && (state_r == ST_ACTIVE) && cnt_zero;
  wire finish = (state_r == ST_GAP) && cnt_zero;

  // command latched only at take; pin decode above looks ahead
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      cmd_r <= dac_host_pkg::CMD_LOAD;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (take) cmd_r <= CMD_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      wdata_r <= dac_host_pkg::CODE_MIN_BIN;
      rssel_r <= 1'b0;
    end else if (take) begin
      wdata_r <= CMD_DATA_I;
      // held until the next take, well past the reset strobe
      rssel_r <= CMD_RESET_LEVEL_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      // pins idle with select released and strobes low
      sel_n_r <= 1'b1;
      rnw_r <= 1'b1;
      oe_r <= 1'b0;
      ld_r <= 1'b0;
      rs_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      sel_n_r <= sel_n_nxt;
      rnw_r <= rnw_nxt;
      oe_r <= oe_nxt;
      ld_r <= ld_nxt;
      rs_r <= rs_nxt;
      done_r <= finish;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_r <= '0;
    end else if (capture) begin
      rdata_r <= bus_sync;
    end
  end

  // format and power-down are registered user levels
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      fmt_r <= 1'b0;
      pd_r <= dac_host_pkg::PD_NORMAL;
    end else begin
      fmt_r <= FORMAT_I;
      pd_r <= PD_I;
    end
  end

  // a held request is taken in the first idle cycle
  assign CMD_READY_O = (state_r == ST_IDLE);
  assign DONE_O = done_r;
  assign RD_DATA_O = rdata_r;
  assign DEV_SELECT_N_O = sel_n_r;
  assign READ_NOT_WRITE_O = rnw_r;
  assign DATA_BUS_LINES_O = wdata_r;
  assign DATA_BUS_LINES_OE_O = oe_r;
  assign LOAD_OUTPUT_STROBE_O = ld_r;
  assign OUTPUT_RESET_STROBE_O = rs_r;
  assign RESET_LEVEL_SELECT_O = rssel_r;
  assign CODE_FORMAT_SELECT_O = fmt_r;
  assign POWERDOWN_SEL1_O = pd_r[1];
  assign POWERDOWN_SEL0_O = pd_r[0];
endmodule

// [dac_host_ctrl_assertions.sv]
/*
  Checker for the converter host controller's pin sequencing.
  Sees only the controller's ports; one clock, sync reset.
*/
module dac_host_ctrl_chk (
  // clock, reset and user side
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CMD_VALID_I,
  input wire logic CMD_READY_O,
  input wire logic DONE_O,
  input wire logic FORMAT_I,
  input wire logic [1:0] PD_I,
  // device pins
  input wire logic DEV_SELECT_N_O,
  input wire logic READ_NOT_WRITE_O,
  input wire logic [15:0] DATA_BUS_LINES_O,
  input wire logic DATA_BUS_LINES_OE_O,
  input wire logic LOAD_OUTPUT_STROBE_O,
  input wire logic OUTPUT_RESET_STROBE_O,
  input wire logic RESET_LEVEL_SELECT_O,
  input wire logic CODE_FORMAT_SELECT_O,
  input wire logic POWERDOWN_SEL1_O,
  input wire logic POWERDOWN_SEL0_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  a_wr_setup: assert property ($fell(DEV_SELECT_N_O) && !READ_NOT_WRITE_O
    |-> !$past(READ_NOT_WRITE_O) && $past(DATA_BUS_LINES_OE_O))
    else $error("write select fell without setup");
  a_rd_setup: assert property ($fell(DEV_SELECT_N_O) && READ_NOT_WRITE_O
    |-> $past(READ_NOT_WRITE_O) && !$past(DATA_BUS_LINES_OE_O))
    else $error("read select fell without rnw setup");
  a_wr_hold: assert property ($rose(DEV_SELECT_N_O)
    && !$past(READ_NOT_WRITE_O) |-> !READ_NOT_WRITE_O
    && DATA_BUS_LINES_OE_O && $stable(DATA_BUS_LINES_O))
    else $error("write data or rnw not held");
  a_rd_low: assert property ($fell(DEV_SELECT_N_O) && READ_NOT_WRITE_O
    |-> (!DEV_SELECT_N_O && READ_NOT_WRITE_O) [*4]
    ##1 DEV_SELECT_N_O && READ_NOT_WRITE_O)
    else $error("read select low length wrong");
  a_rnw_oe: assert property (READ_NOT_WRITE_O |-> !DATA_BUS_LINES_OE_O)
    else $error("host drives bus in read");
  a_ld_pulse: assert property ($rose(LOAD_OUTPUT_STROBE_O)
    |-> DEV_SELECT_N_O ##1 !LOAD_OUTPUT_STROBE_O && DEV_SELECT_N_O)
    else $error("load strobe overlaps access");
  a_rst_sel: assert property ($rose(OUTPUT_RESET_STROBE_O)
    |-> $stable(RESET_LEVEL_SELECT_O)
    ##1 $stable(RESET_LEVEL_SELECT_O) && !OUTPUT_RESET_STROBE_O)
    else $error("reset level not held");
  a_pd_pass: assert property (!$past(RST_I) |->
    {CODE_FORMAT_SELECT_O, POWERDOWN_SEL1_O, POWERDOWN_SEL0_O}
    == {$past(FORMAT_I), $past(PD_I)})
    else $error("format or powerdown pins lag");
  a_take_busy: assert property (CMD_VALID_I && CMD_READY_O
    |=> !CMD_READY_O ##[2:10] DONE_O)
    else $error("command not busy or no done");
  c_write: cover property ($rose(DEV_SELECT_N_O) && !READ_NOT_WRITE_O);
  c_read: cover property ($fell(DEV_SELECT_N_O) && READ_NOT_WRITE_O);
  c_reset: cover property ($rose(OUTPUT_RESET_STROBE_O));
  c_load: cover property ($rose(LOAD_OUTPUT_STROBE_O));
endmodule

bind dac_host_ctrl dac_host_ctrl_chk u_chk (.CLK_SYS_I, .RST_I,
  .CMD_VALID_I, .CMD_READY_O, .DONE_O, .FORMAT_I, .PD_I,
  .DEV_SELECT_N_O, .READ_NOT_WRITE_O, .DATA_BUS_LINES_O,
  .DATA_BUS_LINES_OE_O, .LOAD_OUTPUT_STROBE_O, .OUTPUT_RESET_STROBE_O,
  .RESET_LEVEL_SELECT_O, .CODE_FORMAT_SELECT_O, .POWERDOWN_SEL1_O,
  .POWERDOWN_SEL0_O);

// [dac_dev_model.sv]
/*
  Behavioural model of the clockless parallel converter.
  Assumes the bench resolves the shared data bus.
*/
module dac_dev_model (
  // bus
  input wire logic sel_n_i,
  input wire logic rnw_i,
  input wire logic [15:0] d_i,
  output logic [15:0] d_o,
  // control
  input wire logic ld_i,
  input wire logic rst_i,
  input wire logic rsel_i,
  input wire logic fmt_i,
  input wire logic [1:0] pd_i,
  // state
  output logic [15:0] in_r,
  output logic [15:0] conv_r,
  output logic on_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv;
  // data valid only after worst access delay
  assign #(80, 5) drv = !sel_n_i && rnw_i;
  // released bus shows inverted data, never a kind stale copy
  assign d_o = drv ? in_r : ~in_r;
  assign on_o = (pd_i == dac_host_pkg::PD_NORMAL);
  initial begin
    in_r = 16'h0000;
    // format pin is unknown until the host's first clock edge in reset
    wait (fmt_i !== 1'bx);
    conv_r = fmt_i ? dac_host_pkg::CODE_MIN_TWOS
                   : dac_host_pkg::CODE_MIN_BIN;
  end
  always @(posedge sel_n_i) if (!rnw_i) in_r <= d_i;
  always @(posedge ld_i) conv_r <= in_r;
  always @(posedge rst_i)
    conv_r <= (rsel_i ^ fmt_i) ? 16'h8000 : 16'h0000;
endmodule

// [tb.sv]
/*
  Self-checking bench for the converter host controller.
  Assumes the converter model on the far side of the pins.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, rs = 1'b0, fmt = 1'b0;
  logic [1:0] cmd = 2'h0, pd = 2'h0;
  logic [15:0] wd = 16'h0000, w, rd, ho, dv, bus, in_r, conv;
  logic rdy, done, sel_n, rnw, oe, ld, rsto, rsel, fo, p1, p0;
  logic [15:0] cw [3] = '{16'h0000, 16'hFFFF, 16'h8000};
  int failures = 0, tests_run = 0, seed = 68456, cyc = 0;
  assign bus = oe ? ho : dv;
  always #25 clk = ~clk;
  dac_host_ctrl u_dut (.CLK_SYS_I(clk), .RST_I(rst), .CMD_VALID_I(vld),
    .CMD_I(cmd), .CMD_DATA_I(wd), .CMD_RESET_LEVEL_I(rs), .FORMAT_I(fmt),
    .PD_I(pd), .CMD_READY_O(rdy), .DONE_O(done), .RD_DATA_O(rd),
    .DEV_SELECT_N_O(sel_n), .READ_NOT_WRITE_O(rnw),
    .DATA_BUS_LINES_I(bus), .DATA_BUS_LINES_O(ho),
    .DATA_BUS_LINES_OE_O(oe), .LOAD_OUTPUT_STROBE_O(ld),
    .OUTPUT_RESET_STROBE_O(rsto), .RESET_LEVEL_SELECT_O(rsel),
    .CODE_FORMAT_SELECT_O(fo), .POWERDOWN_SEL1_O(p1),
    .POWERDOWN_SEL0_O(p0));
  dac_dev_model u_dev (.sel_n_i(sel_n), .rnw_i(rnw), .d_i(bus), .d_o(dv),
    .ld_i(ld), .rst_i(rsto), .rsel_i(rsel), .fmt_i(fo), .pd_i({p1, p0}),
    .in_r(in_r), .conv_r(conv), .on_o());
  task automatic stop_test;
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [1:0] c, input logic [15:0] d);
    cmd <= c;
    wd <= d;
    vld <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    vld <= 1'b0;
    do @(posedge clk); while (done !== 1'b1);
  endtask
  function automatic logic [15:0] rst_code(input logic f, input logic r);
    if (r)
      return f ? dac_host_pkg::CODE_MID_TWOS : 16'h8000;
    return f ? dac_host_pkg::CODE_MIN_TWOS : dac_host_pkg::CODE_MIN_BIN;
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({11'h000, sel_n, rnw, oe, ld, rsto}, 16'h0018);
    chk(conv, dac_host_pkg::CODE_MIN_BIN);
    for (int i = 0; i < 12; i++) begin
      w = (i < 3) ? cw[i] : 16'($random(seed));
      fmt <= i[1];
      rs <= i[0];
      pd <= 2'($random(seed));
      // back-to-back writes: only the second may reach the output
      go(dac_host_pkg::CMD_WRITE, 16'($random(seed)));
      go(dac_host_pkg::CMD_WRITE, w);
      chk(in_r, w);
      chk({13'h0000, fo, p1, p0}, {13'h0000, fmt, pd});
      go(dac_host_pkg::CMD_READ, 16'h0000);
      chk(rd, w);
      go(dac_host_pkg::CMD_LOAD, 16'h0000);
      chk(conv, w);
      go(dac_host_pkg::CMD_RESET, 16'h0000);
      chk(conv, rst_code(fmt, rs));
      go(dac_host_pkg::CMD_READ, 16'h0000);
      chk(rd, w);
    end
    stop_test;
  end
endmodule
